// [dswbd_params.svh]
// address map constants and field positions for the data-space decoder
`ifndef DSWBD_PARAMS_SVH
`define DSWBD_PARAMS_SVH
`define DSWBD_BANK_LO        8'h00
`define DSWBD_BANK_HI        8'h3f
`define DSWBD_WIN_LO         8'h40
`define DSWBD_WIN_HI         8'h7f
`define DSWBD_CORE_X         8'h80
`define DSWBD_CORE_W         8'h83
`define DSWBD_RAM_LO         8'h84
`define DSWBD_RAM_HI         8'hbf
`define DSWBD_PORT_DATA      8'hc0
`define DSWBD_PORT_DIR       8'hc4
`define DSWBD_PORT_OPT       8'hcc
`define DSWBD_PORT_CNT       8'h03
`define DSWBD_INT_OPT        8'hc8
`define DSWBD_ROM_WIN_BASE   8'hc9
`define DSWBD_ADC_LO         8'hd0
`define DSWBD_TIMER_STAT     8'hd4
`define DSWBD_PERIPH_HI      8'hdd
`define DSWBD_SPI_DATA       8'he0
`define DSWBD_SPI_HI         8'he2
`define DSWBD_BANK_SEL       8'he8
`define DSWBD_EEPROM_CTL     8'hea
`define DSWBD_ACCUM          8'hff
`define DSWBD_WIN_POS_W      6
`define DSWBD_OFS_W          6
`define DSWBD_RAM_PAGE2_BIT  4
`define DSWBD_EE_PAGE1_BIT   1
`define DSWBD_EE_PAGE0_BIT   0
`define DSWBD_STACK_DEPTH    6
`define DSWBD_PC_W           12
`endif

// [dswbd_pkg.sv]
// types shared by the data-space decoder and its stack
package dswbd_pkg;
  typedef enum logic [4:0] {
    DSWBD_TGT_NONE   = 5'h01,
    DSWBD_TGT_BANK   = 5'h02,
    DSWBD_TGT_WINDOW = 5'h04,
    DSWBD_TGT_LOCAL  = 5'h08,
    DSWBD_TGT_PERIPH = 5'h10
  } dswbd_target_t;
  typedef logic [11:0] dswbd_pc_t;
endpackage : dswbd_pkg

// [dswbd_stack_if.sv]
// push/pop carrier between decoder top and return stack
interface dswbd_stack_if;
  logic                 push;
  logic                 pop;
  dswbd_pkg::dswbd_pc_t push_pc;
  dswbd_pkg::dswbd_pc_t top_pc;
  modport ctrl (output push, output pop, output push_pc, input top_pc);
  modport stk  (input push, input pop, input push_pc, output top_pc);
endinterface : dswbd_stack_if

// [dswbd_stack.sv]
// six-entry 12-bit return-address stack
`include "dswbd_params.svh"
module dswbd_stack (
  input  wire logic     ref_clk_i,  // core clock
  input  wire logic     resetn_i,   // async reset, active low
  dswbd_stack_if.stk    stk         // push/pop port
);
  localparam int DEPTH = `DSWBD_STACK_DEPTH;
  dswbd_pkg::dswbd_pc_t mem      [DEPTH];
  dswbd_pkg::dswbd_pc_t next_mem [DEPTH];
  dswbd_pkg::dswbd_pc_t top_q;
  dswbd_pkg::dswbd_pc_t next_top_q;

  // shift-register stack: push shifts down, pop shifts up, oldest lost
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      next_mem[i] = mem[i];
    end
    if (stk.push) begin
      next_mem[0] = stk.push_pc;
      for (int i = 1; i < DEPTH; i++) begin
        next_mem[i] = mem[i-1];
      end
    end else if (stk.pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        next_mem[i] = mem[i+1];
      end
      next_mem[DEPTH-1] = '0;
    end
    next_top_q = next_mem[0];
  end

  // register the entries and the registered top
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
      top_q <= '0;
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= next_mem[i];
      end
      top_q <= next_top_q;
    end
  end

  assign stk.top_pc = top_q;

  property p_push_top;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      stk.push |=> (stk.top_pc == $past(stk.push_pc));
  endproperty
  a_push_top: assert property (p_push_top) else $error("stack top not the pushed value");

  // a lone push, then a lone pop in the next cycle
  sequence s_push_only;
    stk.push && !stk.pop;
  endsequence
  sequence s_pop_only;
    stk.pop && !stk.push;
  endsequence

  // top seen before the push must come back after the pop
  property p_push_pop;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      s_push_only ##1 s_pop_only |=> (stk.top_pc == $past(stk.top_pc, 2));
  endproperty
  a_push_pop: assert property (p_push_pop) else $error("pop did not restore previous top");
endmodule : dswbd_stack

// [dswbd_decoder.sv]
// data-space decoder: banked low region, rom window, fixed registers, stack
//
// Overview of operation
// - six twelve-bit return stack entries hold the pushed return addresses
// - reads of 40h to 7Fh return bytes fetched from program memory
// - window can reach any program byte from 000h to FFFh
// - program address is window base above the low six data address bits
// - window base is write-only; software never reads it or bit-sets it
// - reset leaves window base untouched; software writes it before use
// - only bits 5 to 0 of window base position the window
// - window base decoded write-only at C9h
// - bank select decoded write-only at E8h
// - bank select bit 4 sends banked accesses to ram page 2
// - bit 1 selects eeprom page 1, bit 0 selects eeprom page 0
// - bank select bits 7 to 5 and 3 to 2 have no effect
// - 00h to 3Fh go to selected bank at same offset
// - reset does not clear bank select; software writes it first
// - interrupts and calls leave bank select unchanged
// - codes 00 none, 01 ee page 0, 02 ee page 1, 10h ram page 2
// - port data at C0h, direction at C4h, option at CCh for A-C
// - timer status at D4h, spi data at E0h, eeprom control at EAh
`include "dswbd_params.svh"
module dswbd_decoder #(
  parameter bit HAS_EEPROM = 1'b1                    // variant with eeprom pages
) (
  input  wire logic        ref_clk_i,                // core clock, 100 MHz
  input  wire logic        resetn_i,                 // async reset, active low
  input  wire logic [7:0]  cpu_addr_i,               // data-space address
  input  wire logic [7:0]  cpu_wdata_i,              // write data
  input  wire logic        cpu_rd_i,                 // read strobe
  input  wire logic        cpu_wr_i,                 // write strobe
  output logic      [7:0]  cpu_rdata_o,              // registered read data
  input  wire logic        call_i,                   // subroutine/interrupt entry
  input  wire logic        ret_i,                    // return
  input  wire logic [11:0] pc_i,                     // pc to push
  output logic      [11:0] ret_pc_o,                 // stack top
  output logic      [11:0] prog_addr_o,              // program memory address
  output logic             prog_rd_o,                // program memory read
  input  wire logic [7:0]  prog_data_i,              // program memory byte
  output logic      [5:0]  bank_addr_o,              // offset inside a bank
  output logic             ram_page2_sel_o,          // ram page 2 access
  output logic             eeprom_page0_sel_o,       // eeprom page 0 access
  output logic             eeprom_page1_sel_o,       // eeprom page 1 access
  input  wire logic [7:0]  bank_rdata_i,             // selected bank read data
  output logic             local_sel_o,              // core regs / data ram
  output logic             periph_sel_o,             // peripheral register
  input  wire logic [7:0]  local_rdata_i,            // core/ram read data
  input  wire logic [7:0]  periph_rdata_i,           // peripheral read data
  output logic      [7:0]  bank_select_o,            // bank select contents
  output logic      [5:0]  window_position_bits_o    // window base contents
);
  // ============================================================
  // write-only registers, no reset value
  logic [7:0] bank_select;
  logic [7:0] next_bank_select;
  logic [5:0] rom_window_base;
  logic [5:0] next_rom_window_base;
  logic       wr_win;
  logic       wr_bank;

  assign wr_win  = cpu_wr_i && (cpu_addr_i == `DSWBD_ROM_WIN_BASE);
  assign wr_bank = cpu_wr_i && (cpu_addr_i == `DSWBD_BANK_SEL);

  // next values; only full-byte writes change them
  always_comb begin
    next_rom_window_base = rom_window_base;
    next_bank_select     = bank_select;
    if (wr_win) begin
      next_rom_window_base = cpu_wdata_i[`DSWBD_WIN_POS_W-1:0];
    end
    if (wr_bank) begin
      next_bank_select = cpu_wdata_i;
    end
  end

  // kept through reset: register has no reset branch
  always_ff @(posedge ref_clk_i) begin
    rom_window_base <= next_rom_window_base;
    bank_select     <= next_bank_select;
  end

  assign bank_select_o          = bank_select;
  assign window_position_bits_o = rom_window_base;

  // ============================================================
  // address decode
  dswbd_pkg::dswbd_target_t tgt;
  logic is_periph;
  logic ram_page2_select;
  logic eeprom_page0_select;
  logic eeprom_page1_select;
  logic any_bank;

  // peripheral map: ports, int option, adc/timers, spi, eeprom control
  always_comb begin
    is_periph = 1'b0;
    if (cpu_addr_i >= `DSWBD_PORT_DATA &&
        cpu_addr_i <  `DSWBD_PORT_DATA + `DSWBD_PORT_CNT) begin
      is_periph = 1'b1;
    end
    if (cpu_addr_i >= `DSWBD_PORT_DIR &&
        cpu_addr_i <  `DSWBD_PORT_DIR + `DSWBD_PORT_CNT) begin
      is_periph = 1'b1;
    end
    if (cpu_addr_i >= `DSWBD_PORT_OPT &&
        cpu_addr_i <  `DSWBD_PORT_OPT + `DSWBD_PORT_CNT) begin
      is_periph = 1'b1;
    end
    if (cpu_addr_i == `DSWBD_INT_OPT) begin
      is_periph = 1'b1;
    end
    if (cpu_addr_i >= `DSWBD_ADC_LO && cpu_addr_i <= `DSWBD_PERIPH_HI) begin
      is_periph = 1'b1;
    end
    if (cpu_addr_i >= `DSWBD_SPI_DATA && cpu_addr_i <= `DSWBD_SPI_HI) begin
      is_periph = 1'b1;
    end
    if (cpu_addr_i == `DSWBD_EEPROM_CTL) begin
      is_periph = 1'b1;
    end
  end

  // page selects from individual bits; unused bits ignored
  assign ram_page2_select    = bank_select[`DSWBD_RAM_PAGE2_BIT];
  assign eeprom_page1_select = HAS_EEPROM && bank_select[`DSWBD_EE_PAGE1_BIT];
  assign eeprom_page0_select = HAS_EEPROM && bank_select[`DSWBD_EE_PAGE0_BIT];
  assign any_bank = ram_page2_select || eeprom_page1_select || eeprom_page0_select;

  // region select
  always_comb begin
    tgt = dswbd_pkg::DSWBD_TGT_NONE;
    if (cpu_addr_i <= `DSWBD_BANK_HI) begin
      tgt = any_bank ? dswbd_pkg::DSWBD_TGT_BANK : dswbd_pkg::DSWBD_TGT_NONE;
    end else if (cpu_addr_i <= `DSWBD_WIN_HI) begin
      tgt = dswbd_pkg::DSWBD_TGT_WINDOW;
    end else if (cpu_addr_i <= `DSWBD_RAM_HI || cpu_addr_i == `DSWBD_ACCUM) begin
      tgt = dswbd_pkg::DSWBD_TGT_LOCAL;
    end else if (is_periph) begin
      tgt = dswbd_pkg::DSWBD_TGT_PERIPH;
    end
  end

  // strobes to targets; write-only regs and reserved addresses go nowhere
  logic acc;
  assign acc                = cpu_rd_i || cpu_wr_i;
  assign bank_addr_o        = cpu_addr_i[`DSWBD_OFS_W-1:0];
  assign ram_page2_sel_o    = acc && (tgt == dswbd_pkg::DSWBD_TGT_BANK) && ram_page2_select;
  assign eeprom_page0_sel_o = acc && (tgt == dswbd_pkg::DSWBD_TGT_BANK) && eeprom_page0_select;
  assign eeprom_page1_sel_o = acc && (tgt == dswbd_pkg::DSWBD_TGT_BANK) && eeprom_page1_select;
  assign local_sel_o        = acc && (tgt == dswbd_pkg::DSWBD_TGT_LOCAL);
  assign periph_sel_o       = acc && (tgt == dswbd_pkg::DSWBD_TGT_PERIPH);
  assign prog_rd_o          = cpu_rd_i && (tgt == dswbd_pkg::DSWBD_TGT_WINDOW);
  assign prog_addr_o        = {rom_window_base, cpu_addr_i[`DSWBD_OFS_W-1:0]};

  // ============================================================
  // read data mux, registered one cycle after the read strobe
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = cpu_rdata_o;
    if (cpu_rd_i) begin
      unique case (tgt)
        dswbd_pkg::DSWBD_TGT_BANK:   next_rdata = bank_rdata_i;
        dswbd_pkg::DSWBD_TGT_WINDOW: next_rdata = prog_data_i;
        dswbd_pkg::DSWBD_TGT_LOCAL:  next_rdata = local_rdata_i;
        dswbd_pkg::DSWBD_TGT_PERIPH: next_rdata = periph_rdata_i;
        dswbd_pkg::DSWBD_TGT_NONE:   next_rdata = 8'hff;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cpu_rdata_o <= 8'h00;
    end else begin
      cpu_rdata_o <= next_rdata;
    end
  end

  // ============================================================
  // return-address stack
  dswbd_stack_if stk_if ();
  assign stk_if.push    = call_i;
  assign stk_if.pop     = ret_i && !call_i;
  assign stk_if.push_pc = pc_i;
  assign ret_pc_o       = stk_if.top_pc;

  dswbd_stack u_stack (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .stk       (stk_if.stk)
  );

  // ============================================================
  // checks
  property p_win_addr;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      prog_rd_o |-> (prog_addr_o[5:0] == cpu_addr_i[5:0] && prog_addr_o[11:6] == rom_window_base);
  endproperty
  a_win_addr: assert property (p_win_addr) else $error("window address wrong");

  property p_win_rdata;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      prog_rd_o |=> (cpu_rdata_o == $past(prog_data_i));
  endproperty
  a_win_rdata: assert property (p_win_rdata) else $error("window read data wrong");

  property p_win_range;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      prog_rd_o |-> (cpu_addr_i >= 8'h40 && cpu_addr_i <= 8'h7f);
  endproperty
  a_win_range: assert property (p_win_range) else $error("window read outside 40h-7Fh");

  property p_win_write;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      (cpu_wr_i && cpu_addr_i == 8'hc9) |=> (rom_window_base == $past(cpu_wdata_i[5:0]));
  endproperty
  a_win_write: assert property (p_win_write) else $error("window base not written");

  property p_bank_write;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      (cpu_wr_i && cpu_addr_i == 8'he8) |=> (bank_select == $past(cpu_wdata_i));
  endproperty
  a_bank_write: assert property (p_bank_write) else $error("bank select not written");

  property p_bank_hold;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      !(cpu_wr_i && cpu_addr_i == 8'he8) |=> $stable(bank_select);
  endproperty
  a_bank_hold: assert property (p_bank_hold) else $error("bank select changed without write");

  property p_ram2;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      (acc && cpu_addr_i <= 8'h3f && bank_select[4]) |-> ram_page2_sel_o;
  endproperty
  a_ram2: assert property (p_ram2) else $error("ram page 2 not selected");

  property p_unused_bits;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      (acc && cpu_addr_i <= 8'h3f && bank_select[4:0] == 5'h00) |->
        !(ram_page2_sel_o || eeprom_page0_sel_o || eeprom_page1_sel_o);
  endproperty
  a_unused_bits: assert property (p_unused_bits) else $error("unused bank bits selected a page");

  property p_no_side;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      (acc && (cpu_addr_i == 8'hc3 || cpu_addr_i == 8'he9 || cpu_addr_i == 8'hc9)) |->
        !(local_sel_o || periph_sel_o || prog_rd_o);
  endproperty
  a_no_side: assert property (p_no_side) else $error("reserved address reached a target");

  property p_periph_map;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      (acc && (cpu_addr_i == 8'hd4 || cpu_addr_i == 8'he0 || cpu_addr_i == 8'hea
               || cpu_addr_i == 8'hc0 || cpu_addr_i == 8'hc4 || cpu_addr_i == 8'hcc)) |-> periph_sel_o;
  endproperty
  a_periph_map: assert property (p_periph_map) else $error("peripheral address not decoded");

  // banked accesses with one of the eeprom page bits set
  sequence s_ee0_acc;
    acc && cpu_addr_i <= 8'h3f && bank_select[0];
  endsequence
  sequence s_ee1_acc;
    acc && cpu_addr_i <= 8'h3f && bank_select[1];
  endsequence

  // eeprom page strobes follow their bits, only on the eeprom variant
  property p_ee0;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      s_ee0_acc |-> (eeprom_page0_sel_o == HAS_EEPROM);
  endproperty
  a_ee0: assert property (p_ee0) else $error("eeprom page 0 select wrong");

  property p_ee1;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      s_ee1_acc |-> (eeprom_page1_sel_o == HAS_EEPROM);
  endproperty
  a_ee1: assert property (p_ee1) else $error("eeprom page 1 select wrong");

  // reads of the write-only registers
  sequence s_wo_read;
    cpu_rd_i && (cpu_addr_i == 8'hc9 || cpu_addr_i == 8'he8);
  endsequence

  property p_wo_read;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      s_wo_read |=> (cpu_rdata_o == 8'hff);
  endproperty
  a_wo_read: assert property (p_wo_read) else $error("write-only register read back");

  // read data holds while no read is made
  property p_rdata_hold;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      !cpu_rd_i |=> $stable(cpu_rdata_o);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed without a read");

  // core registers, data ram and accumulator reach the local target
  property p_local_map;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      (acc && ((cpu_addr_i >= 8'h80 && cpu_addr_i <= 8'hbf) || cpu_addr_i == 8'hff)) |-> local_sel_o;
  endproperty
  a_local_map: assert property (p_local_map) else $error("local address not decoded");
endmodule : dswbd_decoder

// [dswbd_far_model.sv]
// far-side model: program memory, banked pages, core registers and peripherals
module dswbd_far_model (
  input  wire logic        ref_clk_i,     // core clock
  input  wire logic [11:0] prog_addr_i,   // program address
  input  wire logic        prog_rd_i,     // program read
  input  wire logic [5:0]  bank_addr_i,   // bank offset
  input  wire logic [2:0]  bank_sel_i,    // ram2, ee1, ee0
  input  wire logic        local_sel_i,   // core regs or ram
  input  wire logic        periph_sel_i,  // peripheral select
  output logic      [7:0]  prog_data_o,   // program byte
  output logic      [7:0]  bank_rdata_o,  // bank byte
  output logic      [7:0]  local_rdata_o, // local byte
  output logic      [7:0]  periph_rdata_o // peripheral byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] idle_q = 8'h00;
  // idle pattern moves every cycle so stale data never matches
  always_ff @(posedge ref_clk_i) begin
    idle_q <= idle_q + 8'h35;
  end
  // targets answer in the same cycle while selected
  always_comb begin
    prog_data_o    = prog_rd_i ? (prog_addr_i[7:0] ^ {prog_addr_i[11:8], 4'h5}) : idle_q;
    local_rdata_o  = local_sel_i ? 8'h3c : ~idle_q;
    periph_rdata_o = periph_sel_i ? 8'hc3 : idle_q;
    case (bank_sel_i)
      3'b100:  bank_rdata_o = {2'b10, bank_addr_i};
      3'b010:  bank_rdata_o = {2'b01, bank_addr_i};
      3'b001:  bank_rdata_o = {2'b11, bank_addr_i};
      default: bank_rdata_o = ~idle_q;
    endcase
  end
endmodule : dswbd_far_model

// [tb_top.sv]
// self-checking bench for the data-space decoder
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i, resetn_i, rd, wr, call, ret, r2, e1, e0, lsel, psel, prd;
  logic [7:0] addr, wdata, rdata, pdat, bdat, ldat, fdat, bsel, ne_rdata;
  logic [11:0] pc, ret_pc, paddr;
  logic [5:0] boff, wpos;
  int n_mismatch = 0;
  int checked = 0;
  // clock at 100 MHz
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  dswbd_decoder uut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .cpu_addr_i(addr), .cpu_wdata_i(wdata),
    .cpu_rd_i(rd), .cpu_wr_i(wr), .cpu_rdata_o(rdata), .call_i(call), .ret_i(ret), .pc_i(pc),
    .ret_pc_o(ret_pc), .prog_addr_o(paddr), .prog_rd_o(prd), .prog_data_i(pdat), .bank_addr_o(boff),
    .ram_page2_sel_o(r2), .eeprom_page0_sel_o(e0), .eeprom_page1_sel_o(e1), .bank_rdata_i(bdat),
    .local_sel_o(lsel), .periph_sel_o(psel), .local_rdata_i(ldat), .periph_rdata_i(fdat),
    .bank_select_o(bsel), .window_position_bits_o(wpos));
  dswbd_far_model far (.ref_clk_i(ref_clk_i), .prog_addr_i(paddr), .prog_rd_i(prd), .bank_addr_i(boff),
    .bank_sel_i({r2, e1, e0}), .local_sel_i(lsel), .periph_sel_i(psel), .prog_data_o(pdat),
    .bank_rdata_o(bdat), .local_rdata_o(ldat), .periph_rdata_o(fdat));
  // variant without eeprom pages, fed the same bus
  dswbd_decoder #(.HAS_EEPROM(1'b0)) uut_ne (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .cpu_addr_i(addr),
    .cpu_wdata_i(wdata), .cpu_rd_i(rd), .cpu_wr_i(wr), .cpu_rdata_o(ne_rdata), .call_i(call), .ret_i(ret),
    .pc_i(pc), .ret_pc_o(), .prog_addr_o(), .prog_rd_o(), .prog_data_i(pdat), .bank_addr_o(),
    .ram_page2_sel_o(), .eeprom_page0_sel_o(), .eeprom_page1_sel_o(), .bank_rdata_i(bdat), .local_sel_o(),
    .periph_sel_o(), .local_rdata_i(ldat), .periph_rdata_i(fdat), .bank_select_o(), .window_position_bits_o());
  // ==========================================
  // shared checks and bus cycles
  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk_i);
    wr    <= 1'b0;
  endtask : wr_reg
  // read: selects seen in the strobe cycle, data one cycle later
  task automatic rd_chk(input logic [7:0] a, input logic [5:0] sel, input logic [11:0] pa, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr <= a;
    rd   <= 1'b1;
    #1;
    chk("selects", 12'(sel), 12'({prd, r2, e1, e0, lsel, psel}));
    if (sel[5]) chk("prog_addr", pa, paddr);
    @(posedge ref_clk_i);
    rd <= 1'b0;
    #1;
    chk("read data", 12'(d), 12'(rdata));
  endtask : rd_chk
  // ==========================================
  // scenarios
  task automatic t_window();
    wr_reg(8'hc9, 8'he8);
    #1 chk("window bits", 12'h028, 12'(wpos));
    rd_chk(8'h59, 6'h20, 12'ha19, 8'ha0 ^ 8'h19 ^ 8'h19 ^ 8'h19 ^ 8'ha5 ^ 8'ha0);
    wr_reg(8'hc9, 8'h3f);
    rd_chk(8'h7f, 6'h20, 12'hfff, 8'hff ^ 8'hf5);
    rd_chk(8'h40, 6'h20, 12'hfc0, 8'hc0 ^ 8'hf5);
    rd_chk(8'hc9, 6'h00, 12'h000, 8'hff);
    $display("test window done");
  endtask : t_window
  task automatic t_bank();
    logic [10:0] tab [6] = '{11'h410, 11'h101, 11'h202, 11'h000, 11'h008, 11'h0e0};
    logic [5:0] off;
    logic [7:0] d;
    wr_reg(8'hea, 8'h00);
    for (int i = 0; i < 6; i++) begin
      off = i[0] ? 6'h3f : 6'h00;
      d = tab[i][10] ? {2'b10, off} : tab[i][9] ? {2'b01, off} : tab[i][8] ? {2'b11, off} : 8'hff;
      wr_reg(8'h84, tab[i][7:0]);
      wr_reg(8'he8, tab[i][7:0]);
      #1 chk("bank select", 12'(tab[i][7:0]), 12'(bsel));
      rd_chk({2'b00, off}, {1'b0, tab[i][10:8], 2'b00}, 12'h000, d);
      chk("no-eeprom data", 12'(tab[i][10] ? {2'b10, off} : 8'hff), 12'(ne_rdata));
    end
    rd_chk(8'he8, 6'h00, 12'h000, 8'hff);
    $display("test bank done");
  endtask : t_bank
  task automatic t_map();
    logic [9:0] tab [23] = '{10'h280, 10'h283, 10'h284, 10'h2bf, 10'h2ff, 10'h1c0, 10'h1c2, 10'h1c4,
      10'h1c6, 10'h1c8, 10'h1cc, 10'h1ce, 10'h1d0, 10'h1d4, 10'h1dd, 10'h1e0, 10'h1e2, 10'h1ea,
      10'h0c3, 10'h0ca, 10'h0e3, 10'h0e9, 10'h0fe};
    for (int i = 0; i < 23; i++) begin
      rd_chk(tab[i][7:0], {4'h0, tab[i][9:8]}, 12'h000,
        tab[i][9] ? 8'h3c : tab[i][8] ? 8'hc3 : 8'hff);
    end
    $display("test map done");
  endtask : t_map
  task automatic t_stack();
    logic [7:0] keep;
    keep = bsel;
    for (int i = 1; i <= 7; i++) begin
      @(posedge ref_clk_i);
      call <= 1'b1;
      pc   <= 12'ha00 + 12'(i);
      #1;
      if (i > 1) chk("stack top", 12'ha00 + 12'(i - 1), ret_pc);
    end
    // pops start right after the last push
    @(posedge ref_clk_i);
    call <= 1'b0;
    ret  <= 1'b1;
    for (int k = 1; k <= 7; k++) begin
      #1 chk("stack top", (k <= 6) ? 12'ha00 + 12'(8 - k) : 12'h000, ret_pc);
      @(posedge ref_clk_i);
      ret <= (k < 7);
    end
    #1 chk("bank kept", 12'(keep), 12'(bsel));
    chk("stack top", 12'h000, ret_pc);
    $display("test stack done");
  endtask : t_stack
  task automatic t_reset();
    wr_reg(8'hc9, 8'h15);
    wr_reg(8'he8, 8'h01);
    rd_chk(8'h12, 6'h04, 12'h000, 8'hd2);
    @(posedge ref_clk_i);
    call <= 1'b1;
    pc   <= 12'h5a5;
    @(posedge ref_clk_i);
    call <= 1'b0;
    #1 chk("stack top", 12'h5a5, ret_pc);
    // mid-run reset: write-only registers must survive it
    @(posedge ref_clk_i);
    resetn_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    #1 chk("reset rdata", 12'h000, 12'(rdata));
    chk("window kept", 12'h015, 12'(wpos));
    chk("bank kept", 12'h001, 12'(bsel));
    chk("reset stack", 12'h000, ret_pc);
    rd_chk(8'h7e, 6'h20, 12'h57e, 8'h7e ^ 8'h55);
    $display("test reset done");
  endtask : t_reset
  // ==========================================
  // main sequence and hang guard
  initial begin
    {rd, wr, call, ret} = 4'h0;
    addr     = 8'h00;
    wdata    = 8'h00;
    pc       = 12'h000;
    resetn_i = 1'b0;
    // seed write-only registers during reset; they have no reset value
    @(posedge ref_clk_i);
    wr   <= 1'b1;
    addr <= 8'he8;
    @(posedge ref_clk_i);
    addr <= 8'hc9;
    @(posedge ref_clk_i);
    wr   <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    #1 chk("reset rdata", 12'h000, 12'(rdata));
    chk("reset stack", 12'h000, ret_pc);
    chk("seeded bank", 12'h000, 12'(bsel));
    chk("seeded window", 12'h000, 12'(wpos));
    t_window();
    t_bank();
    t_map();
    t_reset();
    t_stack();
    close_out();
  end
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    n_mismatch++;
    close_out();
  end
endmodule : tb_top
